// [rtl/cursor_two_pkg.sv]
package cursor_two_pkg;
	localparam logic [7:0] IDX_CONTROL = 8'hA8;
	localparam logic [7:0] IDX_HEIGHT_EXT = 8'hA9;
	localparam logic [7:0] IDX_BASE_LOW = 8'hAA;
	localparam logic [7:0] IDX_BASE_HIGH = 8'hAB;
	localparam logic [7:0] IDX_XPOS_LOW = 8'hAC;
	localparam logic [7:0] IDX_XPOS_HIGH = 8'hAD;
	localparam logic [7:0] IDX_YPOS_LOW = 8'hAE;
	localparam logic [7:0] IDX_YPOS_HIGH = 8'hAF;
	localparam int CTL_MODE_LSB = 0;
	localparam int CTL_EXT_EN_BIT = 3;
	localparam int CTL_ORIGIN_BIT = 4;
	localparam int CTL_HSTRETCH_BIT = 5;
	localparam int CTL_VSTRETCH_BIT = 6;
	localparam int CTL_BLINK_BIT = 7;
	localparam int POS_SIGN_BIT = 7;
	localparam logic [7:0] BASE_HIGH_MASK = 8'h3F;
	localparam logic [7:0] POS_HIGH_MASK = 8'h87;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] INDEX_RESET = 8'h00;
endpackage

// [rtl/cursor_two_placement_regs.sv]
`timescale 1ns/100ps
module cursor_two_placement_regs (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// Host index/data port, core-clock strobes
	input wire logic i_index_wr,
	input wire logic i_data_wr,
	input wire logic i_data_rd,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	output logic [7:0] o_index,
	// Display timing
	input wire logic i_frame_start,
	// Cursor overlay outputs
	output logic [2:0] o_mode,
	output logic o_blink_en,
	output logic o_hstretch_en,
	output logic o_vstretch_en,
	output logic o_origin_active,
	output logic o_height_ext_en,
	output logic [10:0] o_height_lines,
	output logic [21:0] o_base_offset,
	output logic [3:0] o_pattern,
	output logic o_xpos_sign,
	output logic [10:0] o_xpos_mag,
	output logic o_ypos_sign,
	output logic [10:0] o_ypos_mag
);
	logic [7:0] index_r;
	logic [7:0] control_r;
	logic [7:0] height_ext_r;
	logic [7:0] base_low_r;
	logic [7:0] base_high_r;
	logic [7:0] xpos_low_r;
	logic [7:0] xpos_high_r;
	logic [7:0] ypos_low_r;
	logic [7:0] ypos_high_r;
	logic [7:0] rdata_nxt;

	function automatic logic [10:0] pos_mag(input logic [7:0] low, input logic [7:0] high);
		pos_mag = {high[2:0], low};
	endfunction

	// A data write lands in the register that the index held before that clock edge.
	function automatic logic reg_hit(input logic [7:0] idx);
		reg_hit = i_data_wr && (index_r == idx);
	endfunction

	// Eleven bits are needed: an extension value of 8'hFF means 1024 scan lines.
	function automatic logic [10:0] height_lines(input logic [7:0] ext);
		height_lines = {1'b0, ext, 2'b00} + 11'h004;
	endfunction

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			index_r <= cursor_two_pkg::INDEX_RESET;
		end else if (i_index_wr) begin
			index_r <= i_wdata;
		end
	end

	// Reserved bits are dropped on the way in, so they read back as zero.
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			control_r <= cursor_two_pkg::CONTROL_RESET;
		end else if (reg_hit(cursor_two_pkg::IDX_CONTROL)) begin
			control_r <= i_wdata;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			height_ext_r <= cursor_two_pkg::DATA_RESET;
		end else if (reg_hit(cursor_two_pkg::IDX_HEIGHT_EXT)) begin
			height_ext_r <= i_wdata;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			base_low_r <= cursor_two_pkg::DATA_RESET;
		end else if (reg_hit(cursor_two_pkg::IDX_BASE_LOW)) begin
			base_low_r <= i_wdata;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			base_high_r <= cursor_two_pkg::DATA_RESET;
		end else if (reg_hit(cursor_two_pkg::IDX_BASE_HIGH)) begin
			base_high_r <= i_wdata & cursor_two_pkg::BASE_HIGH_MASK;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			xpos_low_r <= cursor_two_pkg::DATA_RESET;
		end else if (reg_hit(cursor_two_pkg::IDX_XPOS_LOW)) begin
			xpos_low_r <= i_wdata;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			xpos_high_r <= cursor_two_pkg::DATA_RESET;
		end else if (reg_hit(cursor_two_pkg::IDX_XPOS_HIGH)) begin
			xpos_high_r <= i_wdata & cursor_two_pkg::POS_HIGH_MASK;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			ypos_low_r <= cursor_two_pkg::DATA_RESET;
		end else if (reg_hit(cursor_two_pkg::IDX_YPOS_LOW)) begin
			ypos_low_r <= i_wdata;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			ypos_high_r <= cursor_two_pkg::DATA_RESET;
		end else if (reg_hit(cursor_two_pkg::IDX_YPOS_HIGH)) begin
			ypos_high_r <= i_wdata & cursor_two_pkg::POS_HIGH_MASK;
		end
	end

	// Indices outside this group read as zero so a shared data port can OR the answers.
	always_comb begin
		unique case (index_r)
			cursor_two_pkg::IDX_CONTROL: rdata_nxt = control_r;
			cursor_two_pkg::IDX_HEIGHT_EXT: rdata_nxt = height_ext_r;
			cursor_two_pkg::IDX_BASE_LOW: rdata_nxt = base_low_r;
			cursor_two_pkg::IDX_BASE_HIGH: rdata_nxt = base_high_r;
			cursor_two_pkg::IDX_XPOS_LOW: rdata_nxt = xpos_low_r;
			cursor_two_pkg::IDX_XPOS_HIGH: rdata_nxt = xpos_high_r;
			cursor_two_pkg::IDX_YPOS_LOW: rdata_nxt = ypos_low_r;
			cursor_two_pkg::IDX_YPOS_HIGH: rdata_nxt = ypos_high_r;
			default: rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_rdata <= 8'h00;
		end else if (i_data_rd) begin
			o_rdata <= rdata_nxt;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_index <= cursor_two_pkg::INDEX_RESET;
		end else if (i_index_wr) begin
			o_index <= i_wdata;
		end
	end

	// Shadow copies change only at frame start, so split multi-register updates show only if a frame start falls between their writes.
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_mode <= 3'h0;
			o_blink_en <= 1'b0;
			o_hstretch_en <= 1'b0;
			o_vstretch_en <= 1'b0;
		end else if (i_frame_start) begin
			o_mode <= control_r[cursor_two_pkg::CTL_MODE_LSB +: 3];
			o_blink_en <= control_r[cursor_two_pkg::CTL_BLINK_BIT];
			o_hstretch_en <= control_r[cursor_two_pkg::CTL_HSTRETCH_BIT];
			o_vstretch_en <= control_r[cursor_two_pkg::CTL_VSTRETCH_BIT];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_origin_active <= 1'b0;
			o_height_ext_en <= 1'b0;
		end else if (i_frame_start) begin
			o_origin_active <= control_r[cursor_two_pkg::CTL_ORIGIN_BIT];
			o_height_ext_en <= control_r[cursor_two_pkg::CTL_EXT_EN_BIT];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_height_lines <= 11'h004;
		end else if (i_frame_start) begin
			o_height_lines <= height_lines(height_ext_r);
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_base_offset <= 22'h000000;
			o_pattern <= 4'h0;
		end else if (i_frame_start) begin
			o_base_offset <= {base_high_r[5:0], base_low_r[7:4], 12'h000};
			o_pattern <= base_low_r[3:0];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_xpos_sign <= 1'b0;
			o_xpos_mag <= 11'h000;
		end else if (i_frame_start) begin
			o_xpos_sign <= xpos_high_r[cursor_two_pkg::POS_SIGN_BIT];
			o_xpos_mag <= pos_mag(xpos_low_r, xpos_high_r);
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_ypos_sign <= 1'b0;
			o_ypos_mag <= 11'h000;
		end else if (i_frame_start) begin
			o_ypos_sign <= ypos_high_r[cursor_two_pkg::POS_SIGN_BIT];
			o_ypos_mag <= pos_mag(ypos_low_r, ypos_high_r);
		end
	end
endmodule

// [tb/cursor_two_assertions.sv]
`timescale 1ns/100ps
module cursor_two_assertions (
	// Host side
	input wire logic i_core_clk, i_rst, i_data_wr, i_data_rd, i_frame_start,
	input wire logic [7:0] i_wdata, o_rdata, o_index,
	// Overlay side
	input wire logic o_height_ext_en, o_origin_active, o_xpos_sign,
	input wire logic [10:0] o_height_lines,
	input wire logic [21:0] o_base_offset,
	input wire logic [3:0] o_pattern,
	input wire logic [10:0] o_xpos_mag, o_ypos_mag
);
	logic [7:0] w1, w2;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	// Keeps the data of a write for the frame start that follows it.
	always_ff @(posedge i_core_clk) begin
		w1 <= i_wdata;
		w2 <= w1;
	end
	sequence s_wf(logic [7:0] ix);
		i_data_wr && o_index == ix ##1 i_frame_start && !i_data_wr;
	endsequence
	property p_rst; $fell(i_rst) |-> !o_height_ext_en && !o_origin_active && o_height_lines == 10'h004; endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	property p_ht; s_wf(8'hA9) |=> o_height_lines == ({3'h0, w2} + 11'h001) * 11'h004; endproperty
	a_ht: assert property (p_ht) else $error("height");
	property p_blo; s_wf(8'hAA) |=> o_base_offset[15:0] == {w2[7:4], 12'h000} && o_pattern == w2[3:0]; endproperty
	a_blo: assert property (p_blo) else $error("base low");
	property p_bhi; s_wf(8'hAB) |=> o_base_offset[21:16] == w2[5:0]; endproperty
	a_bhi: assert property (p_bhi) else $error("base high");
	property p_res; i_data_rd && o_index == 8'hAB |=> o_rdata[7:6] == 2'h0; endproperty
	a_res: assert property (p_res) else $error("reserved bits");
	property p_x; s_wf(8'hAD) |=> o_xpos_sign == w2[7] && o_xpos_mag[10:8] == w2[2:0]; endproperty
	a_x: assert property (p_x) else $error("xpos");
	property p_y; s_wf(8'hAE) |=> o_ypos_mag[7:0] == w2; endproperty
	a_y: assert property (p_y) else $error("ypos");
	property p_hold; !i_frame_start |=> $stable(o_base_offset) && $stable(o_xpos_mag) && $stable(o_ypos_mag); endproperty
	a_hold: assert property (p_hold) else $error("shadow moved");
endmodule
bind cursor_two_placement_regs cursor_two_assertions cursor_two_assertions_i (.*);

// [tb/testbench.sv]
`timescale 1ns/100ps
module testbench;
	logic i_core_clk = 0, i_rst = 1, i_index_wr = 0, i_data_wr = 0, i_data_rd = 0, i_frame_start = 0;
	logic [7:0] i_wdata = 8'h00, o_rdata, o_index, v;
	logic [2:0] o_mode;
	logic o_blink_en, o_hstretch_en, o_vstretch_en, o_origin_active, o_height_ext_en, o_xpos_sign, o_ypos_sign;
	logic [10:0] o_height_lines;
	logic [21:0] o_base_offset;
	logic [3:0] o_pattern;
	logic [10:0] o_xpos_mag, o_ypos_mag;
	logic [7:0] m [8];
	logic [68:0] e, outs;
	int err_count = 0, tests_run = 0;
	cursor_two_placement_regs cursor_two_placement_regs_i (.*);
	assign outs = {o_mode, o_blink_en, o_hstretch_en, o_vstretch_en, o_origin_active, o_height_ext_en,
		o_height_lines, o_base_offset, o_pattern, o_xpos_sign, o_xpos_mag, o_ypos_sign, o_ypos_mag};
	always #4 i_core_clk = ~i_core_clk;
	function automatic logic [68:0] ex();
		return {m[0][2:0], m[0][7], m[0][5], m[0][6], m[0][4], m[0][3], ({3'h0, m[1]} + 11'h001) << 2,
			m[3][5:0], m[2][7:4], 12'h000, m[2][3:0], m[5][7], m[5][2:0], m[4], m[7][7], m[7][2:0], m[6]};
	endfunction
	task automatic chk(logic [68:0] got, logic [68:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic acc(logic [7:0] ix, logic rd, logic [7:0] d);
		@(posedge i_core_clk);
		i_index_wr <= 1;
		i_wdata <= ix;
		@(posedge i_core_clk);
		i_index_wr <= 0;
		i_data_wr <= !rd;
		i_data_rd <= rd;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_data_wr <= 0;
		i_data_rd <= 0;
		if (rd) begin
			#1 chk(o_rdata, d);
		end
	endtask
	task automatic final_report();
		$display("tests %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		void'($urandom(32'h8F74CC9C));
		foreach (m[a]) m[a] = 8'h00;
		repeat (5) @(posedge i_core_clk);
		i_rst <= 0;
		#1 chk(outs, ex());
		for (int k = 0; k < 12; k++) begin
			e = ex();
			for (int a = 0; a < 8; a++) begin
				v = k == 0 ? 8'hFF : k == 1 ? 8'h00 : 8'($urandom);
				acc(8'(8'hA8 + a), 0, v);
				m[a] = v & (a == 3 ? 8'h3F : (a == 5 || a == 7) ? 8'h87 : 8'hFF);
			end
			acc(8'(8'hB0 + k), 0, v);
			acc(8'(8'hB0 + k), 1, 8'h00);
			chk(outs, e);
			for (int a = 0; a < 8; a++) acc(8'(8'hA8 + a), 1, m[a]);
			v = 8'($urandom);
			acc(8'(8'hA9 + k % 7), 0, v);
			m[1 + k % 7] = v & (k % 7 == 2 ? 8'h3F : (k % 7 == 4 || k % 7 == 6) ? 8'h87 : 8'hFF);
			i_frame_start <= 1;
			@(posedge i_core_clk);
			i_frame_start <= 0;
			#1 chk(outs, ex());
			$display("test %0d done", k);
		end
		final_report();
	end
	initial begin
		repeat (5000) @(posedge i_core_clk);
		err_count++;
		final_report();
	end
endmodule
